/* File: bench/hpm_host_model.sv */
// host serial master sending frames on either serial channel
`timescale 1ns/1ps
module hpm_host_model
(
	// bench control
	input wire logic start,
	input wire logic [15:0] word,
	output logic done,
	output logic [7:0] reply,
	// serial pins
	output logic sck,
	output logic sel_n,
	output logic mosi,
	input wire logic miso
);
	logic [15:0] rx;
	assign reply = rx[7:0];
	// reply bits are taken on rising edges, the slave shifts on falling ones
	always @(posedge sck)
		rx <= {rx[14:0], miso};
	initial
	begin
		done = 1'b0;
		sck = 1'b0;
		sel_n = 1'b1;
		mosi = 1'b1;
	end
	// clock runs only inside a frame, msb first
	always @(posedge start)
	begin
		done = 1'b0;
		#7 sel_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			mosi = word[i];
			#16 sck = 1'b1;
			#16 sck = 1'b0;
		end
		#16 sel_n = 1'b1;
		mosi = ~mosi;
		done = 1'b1;
	end
endmodule

/* File: bench/hpm_host_port_bench.sv */
// self-checking bench for the host port pin mux block
`timescale 1ns/1ps
module hpm_host_port_bench
	import hpm_pkg::*;
;
	logic clk, nrst, sa, sb, prst_n, ce_n, oe_n, we_n, chb, cha, m_start, m_done, m_sck, m_sel, m_mosi, par;
	logic ack_n, doe, poe, pout, wv, sres, por, a0o, a0e, a4o, a4e;
	logic [4:0] addr, rda;
	logic [7:0] dat, blin, rnd, dout, rdd, m_reply;
	logic [2:0] lvf;
	logic [3:0] blo;
	wire [3:0] bhi;
	logic [15:0] m_word;
	hpm_wr_t wr;
	hpm_mode_t mode;
	hpm_wr_t exp_q[$];
	int num_errors, comparisons, i;
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// register file contents as the bench models them
	function automatic logic [7:0] rmodel(input logic [4:0] a);
		return {a[2:0], a} ^ 8'h3c;
	endfunction
	assign rdd = rmodel(rda);
	hpm_host_model host (.start(m_start), .word(m_word), .done(m_done), .reply(m_reply), .sck(m_sck),
		.sel_n(m_sel), .mosi(m_mosi), .miso(cha ? a0o : a4o));
	hpm_host_port #(.RESET_STRETCH(4), .POR_READY(8)) dut (.clk(clk), .nrst(nrst), .strap_chan_a(sa),
		.strap_chan_b(sb), .pin_reset_n(prst_n), .channel_a_select_n(cha ? m_sel : ce_n),
		.pin_oe_n_sck_a(cha ? m_sck : oe_n), .pin_we_n_mosi_a(cha ? m_mosi : we_n), .write_ack_n(ack_n),
		.pin_a0_in(a0e ? a0o : addr[0]), .pin_a0_out(a0o),
		.pin_a0_oe(a0e), .channel_b_select_n(chb ? m_sel : addr[1]), .channel_b_serial_clock(chb ? m_sck : addr[2]),
		.pin_a3_mosi_b(chb ? m_mosi : addr[3]), .pin_a4_in(a4e ? a4o : addr[4]), .pin_a4_out(a4o), .pin_a4_oe(a4e),
		.bus_data_in(doe ? dout : dat), .bus_data_out(dout), .bus_data_oe(doe), .bus_parity_bit_in(poe ? pout : par),
		.bus_parity_bit_out(pout), .bus_parity_bit_oe(poe), .bilevel_in(blin), .low_voltage_flag(lvf),
		.bilevel_out_1_to_4(blo), .bilevel_out_5(bhi[0]), .bilevel_out_6(bhi[1]), .bilevel_out_7(bhi[2]),
		.bilevel_out_8(bhi[3]), .reg_wr_valid(wv), .reg_wr(wr), .reg_rd_addr(rda), .reg_rd_data(rdd),
		.settings_reset(sres), .power_on_ready(por), .host_mode(mode));
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] ex);
		comparisons++;
		if (seen !== ex)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, ex, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// write results come off the queue as they appear
	always @(negedge clk)
		if (wv === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("no write", {3'h0, wr}, 16'hffff);
			else
				chk("write", {3'h0, wr}, {3'h0, exp_q.pop_front()});
		end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic wait_out;
		for (i = 0; i < 300 && sres !== 1'b0; i++)
			@(negedge clk);
		if (i == 300)
		begin
			num_errors++;
			complete_run;
		end
	endtask
	task automatic pwr(input logic [4:0] a, input logic [7:0] d, input logic bad);
		@(negedge clk);
		addr = a;
		dat = d;
		par = (^{a, d}) ^ bad;
		ce_n = 1'b0;
		we_n = 1'b0;
		if (!bad)
			exp_q.push_back({a, d});
		repeat (4) @(negedge clk);
		we_n = 1'b1;
		repeat (8) @(negedge clk);
		ce_n = 1'b1;
		chk("ack", {15'h0, ack_n}, {15'h0, bad});
		repeat (4) @(negedge clk);
	endtask
	task automatic prd(input logic [4:0] a);
		logic [7:0] d;
		d = rmodel(a);
		@(negedge clk);
		addr = a;
		ce_n = 1'b0;
		oe_n = 1'b0;
		repeat (8) @(negedge clk);
		chk("rd data", {7'h0, doe, dout}, {7'h0, 1'b1, d});
		chk("rd parity", {15'h0, pout}, {15'h0, ^{a, d}});
		ce_n = 1'b1;
		oe_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask
	task automatic blv(input logic inrst);
		rnd = lfsr(rnd);
		blin = rnd;
		lvf = rnd[7:5];
		repeat (6) @(negedge clk);
		if (inrst)
			chk("blo rst", {8'h0, bhi, blo}, {8'h0, 1'b1, lvf[0], lvf[1], lvf[2], rnd[3:0]});
		else
			chk("blo", {8'h0, bhi, blo}, {8'h0, rnd});
	endtask
	// one frame from the host model; the first wait lets the model clear its done flag
	task automatic sfr(input logic [15:0] w);
		m_word = w;
		if (w[15])
			exp_q.push_back({w[12:8], w[7:0]});
		m_start = 1'b1;
		@(negedge clk);
		for (i = 0; i < 100 && m_done !== 1'b1; i++)
			@(negedge clk);
		m_start = 1'b0;
		if (i == 100)
		begin
			num_errors++;
			complete_run;
		end
		repeat (10) @(negedge clk);
	endtask
	// new straps under pin reset, a write frame, then two reads: the second reply carries the first address
	task automatic serial_test(input logic [3:0] straps, input hpm_mode_t md, input logic [15:0] w);
		prst_n = 1'b0;
		{sa, sb, chb, cha} = straps;
		repeat (6) @(negedge clk);
		prst_n = 1'b1;
		wait_out;
		chk("mode", {12'h0, a0e, a4e, mode}, {12'h0, md == HPM_MODE_CHAN_A, md == HPM_MODE_CHAN_B, md});
		sfr(w);
		chk("ack serial", {14'h0, ack_n, exp_q.size() == 0}, 16'h0001);
		rnd = lfsr(rnd);
		sfr({3'h0, rnd[4:0], 8'h00});
		sfr({3'h0, rnd[7:3], 8'h00});
		chk("reply", {8'h0, m_reply}, {8'h0, rmodel(rnd[4:0])});
	endtask
	initial
	begin
		num_errors = 0;
		comparisons = 0;
		{nrst, sa, sb, prst_n, ce_n, oe_n, we_n, chb, cha, m_start} = 10'h1f8;
		{addr, dat, par, blin, lvf, m_word} = '0;
		rnd = 8'h2b;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		wait_out;
		chk("mode", {14'h0, mode}, {14'h0, HPM_MODE_PARALLEL});
		pwr(5'h15, 8'ha7, 1'b0);
		pwr(5'h0a, 8'h3c, 1'b1);
		pwr(5'h1f, 8'hff, 1'b0);
		$display("parallel write test done");
		for (int k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			prd(rnd[4:0]);
		end
		$display("parallel read test done");
		repeat (3) blv(1'b0);
		prst_n = 1'b0;
		repeat (5) blv(1'b1);
		chk("reset", {15'h0, sres}, 16'h0001);
		prst_n = 1'b1;
		wait_out;
		blv(1'b0);
		pwr(5'h00, 8'h6a, 1'b0);
		wait_out;
		$display("reset test done");
		serial_test(4'ha, HPM_MODE_CHAN_B, {1'b1, 2'b00, 5'h0d, 8'hc5});
		serial_test(4'h5, HPM_MODE_CHAN_A, {1'b1, 2'b00, 5'h13, 8'h5e});
		$display("serial test done");
		complete_run;
	end
endmodule
bind hpm_host_port hpm_host_port_properties u_props (.clk(clk), .nrst(nrst), .reg_wr_valid(reg_wr_valid),
	.reg_wr(reg_wr), .write_ack_n(write_ack_n), .settings_reset(settings_reset), .power_on_ready(power_on_ready),
	.bus_data_oe(bus_data_oe), .bus_parity_bit_oe(bus_parity_bit_oe), .pin_a4_oe(pin_a4_oe), .host_mode(host_mode),
	.bilevel_in(bilevel_in), .low_voltage_flag(low_voltage_flag), .bilevel_out_1_to_4(bilevel_out_1_to_4),
	.bilevel_out_5(bilevel_out_5), .bilevel_out_8(bilevel_out_8));

/* File: bench/hpm_host_port_properties.sv */
// assertions on the host port pins of the pin mux block
`timescale 1ns/1ps
module hpm_host_port_properties
	import hpm_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic nrst,
	input wire logic reg_wr_valid,
	input wire hpm_wr_t reg_wr,
	input wire logic write_ack_n,
	input wire logic settings_reset,
	input wire logic power_on_ready,
	input wire logic bus_data_oe,
	input wire logic bus_parity_bit_oe,
	input wire logic pin_a4_oe,
	input wire hpm_mode_t host_mode,
	input wire logic [NUM_BILEVEL-1:0] bilevel_in,
	input wire logic [LVF_W-1:0] low_voltage_flag,
	input wire logic [3:0] bilevel_out_1_to_4,
	input wire logic bilevel_out_5,
	input wire logic bilevel_out_8
);
	logic [2:0] up;
	// input synchronisers need a few edges after reset before outputs mean anything
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence calm;
		(up == 3'h7 && $stable(bilevel_in) && $stable(low_voltage_flag) && $stable(settings_reset)
			&& $stable(power_on_ready))[*4];
	endsequence
	// acknowledge and write strobe leave the same register stage, so they meet in one cycle
	wr_ack_low_a: assert property (reg_wr_valid |-> !write_ack_n)
		else $error("ack not low with write");
	blo_low_a: assert property (calm |-> bilevel_out_1_to_4 == bilevel_in[3:0])
		else $error("outputs 1 to 4 wrong");
	blo_five_a: assert property (calm |-> bilevel_out_5 == (settings_reset ? low_voltage_flag[LVF_VCC_BIT] : bilevel_in[4]))
		else $error("output 5 wrong");
	blo_eight_a: assert property (calm |-> bilevel_out_8 == (settings_reset ? power_on_ready : bilevel_in[7]))
		else $error("output 8 wrong");
	par_oe_a: assert property (bus_data_oe |-> bus_parity_bit_oe && host_mode == HPM_MODE_PARALLEL)
		else $error("parity not driven with data");
	miso_b_oe_a: assert property ($stable(host_mode)[*2] |-> pin_a4_oe == (host_mode == HPM_MODE_CHAN_B))
		else $error("a4 enable wrong");
	no_wr_reset_a: assert property (settings_reset && $past(settings_reset) |-> !reg_wr_valid)
		else $error("write in reset");
	soft_rst_a: assert property (reg_wr_valid && reg_wr == {MASTER_RESET_ADDR, MASTER_RESET_MAGIC} |=> settings_reset[*3])
		else $error("soft reset missing");
endmodule

/* File: pkg/hpm_pkg.sv */
// shared constants, types and helpers for the host port pin mux block
package hpm_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_STRETCH_NS = 1000;
	localparam int RESET_STRETCH_CYCLES = (RESET_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_READY_NS = 2000;
	localparam int POR_READY_CYCLES = (POR_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_BILEVEL = 8;
	localparam int LVF_W = 3;

	localparam logic [4:0] MASTER_RESET_ADDR = 5'h00;
	localparam logic [7:0] MASTER_RESET_MAGIC = 8'h6a;

	// bit positions of the supply flags inside the power status word
	localparam int LVF_VCC_BIT = 2;
	localparam int LVF_VEE_BIT = 1;
	localparam int LVF_5V_BIT = 0;

	// serial frame: command byte (write flag, address) then one data byte
	localparam logic [3:0] SPI_CMD_LAST = 4'h7;
	localparam logic [3:0] SPI_DATA_FIRST = 4'h8;
	localparam logic [3:0] SPI_FRAME_LAST = 4'hf;
	localparam int SPI_WRITE_BIT = 15;

	localparam logic ACK_IDLE = 1'b1;
	localparam logic ACK_GOOD = 1'b0;
	localparam logic ACK_ERROR = 1'b1;

	typedef enum logic [1:0] {
		HPM_MODE_NONE,
		HPM_MODE_CHAN_A,
		HPM_MODE_CHAN_B,
		HPM_MODE_PARALLEL
	} hpm_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} hpm_wr_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic parity;
	} hpm_par_pins_t;

	// parity bit that makes address, data and parity even in ones
	function automatic logic hpm_parity(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		return ^{addr, data};
	endfunction

	function automatic hpm_mode_t hpm_decode_mode(input logic strap_a, input logic strap_b);
		hpm_mode_t m;
		m = HPM_MODE_NONE;
		case ({strap_a, strap_b})
			2'b11: m = HPM_MODE_PARALLEL;
			2'b01: m = HPM_MODE_CHAN_A;
			2'b10: m = HPM_MODE_CHAN_B;
			default: m = HPM_MODE_NONE;
		endcase
		return m;
	endfunction

endpackage

/* File: src/hpm_host_port.sv */
// host facing pin mux, parallel bus with parity, serial channels and reset logic
`timescale 1ns/1ps
module hpm_host_port
	import hpm_pkg::*;
#(
	parameter int RESET_STRETCH = RESET_STRETCH_CYCLES,
	parameter int POR_READY = POR_READY_CYCLES
)
(
	// system
	input wire logic clk,
	input wire logic nrst,
	// straps
	input wire logic strap_chan_a,
	input wire logic strap_chan_b,
	// control pins
	input wire logic pin_reset_n,
	input wire logic channel_a_select_n,
	input wire logic pin_oe_n_sck_a,
	input wire logic pin_we_n_mosi_a,
	output logic write_ack_n,
	// shared address pins
	input wire logic pin_a0_in,
	output logic pin_a0_out,
	output logic pin_a0_oe,
	input wire logic channel_b_select_n,
	input wire logic channel_b_serial_clock,
	input wire logic pin_a3_mosi_b,
	input wire logic pin_a4_in,
	output logic pin_a4_out,
	output logic pin_a4_oe,
	// data bus and parity
	input wire logic [DATA_W-1:0] bus_data_in,
	output logic [DATA_W-1:0] bus_data_out,
	output logic bus_data_oe,
	input wire logic bus_parity_bit_in,
	output logic bus_parity_bit_out,
	output logic bus_parity_bit_oe,
	// bilevel monitor
	input wire logic [NUM_BILEVEL-1:0] bilevel_in,
	input wire logic [LVF_W-1:0] low_voltage_flag,
	output logic [3:0] bilevel_out_1_to_4,
	output logic bilevel_out_5,
	output logic bilevel_out_6,
	output logic bilevel_out_7,
	output logic bilevel_out_8,
	// register file side
	output logic reg_wr_valid,
	output hpm_wr_t reg_wr,
	output logic [ADDR_W-1:0] reg_rd_addr,
	input wire logic [DATA_W-1:0] reg_rd_data,
	output logic settings_reset,
	output logic power_on_ready,
	output hpm_mode_t host_mode
);

	// pin synchronisers
	hpm_par_pins_t par_s1;
	hpm_par_pins_t par_s2;
	hpm_par_pins_t par_prev;
	hpm_par_pins_t par_pins;
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	logic rst_pin_s1;
	logic rst_pin_s2;
	logic [NUM_BILEVEL-1:0] comp_s1;
	logic [NUM_BILEVEL-1:0] comp_s2;
	logic [LVF_W-1:0] lvf_s1;
	logic [LVF_W-1:0] lvf_s2;

	// serial channel crossing: {a_wr, a_rd, b_wr, b_rd}
	logic [3:0] tog;
	logic [3:0] tog_s1;
	logic [3:0] tog_s2;
	logic [3:0] tog_s3;
	logic [3:0] tog_pulse;
	hpm_wr_t frame_a;
	hpm_wr_t frame_b;
	logic [ADDR_W-1:0] rd_addr_a;
	logic [ADDR_W-1:0] rd_addr_b;
	logic miso_a;
	logic miso_b;
	logic sel_a_n;
	logic sel_b_n;

	// control state
	logic [CNT_W-1:0] rst_cnt;
	logic [CNT_W-1:0] por_cnt;
	logic in_reset;
	logic [DATA_W-1:0] rd_hold;
	logic rd_parity;

	// decode
	logic mode_par;
	logic mode_a;
	logic mode_b;
	logic par_write_end;
	logic par_parity_ok;
	logic par_reading;
	logic spi_write;
	hpm_wr_t spi_frame;
	logic any_write;
	hpm_wr_t next_wr;
	logic soft_reset;
	logic next_ack;
	logic [ADDR_W-1:0] next_rd_addr;

	assign mode_par = host_mode == HPM_MODE_PARALLEL;
	assign mode_a = host_mode == HPM_MODE_CHAN_A;
	assign mode_b = host_mode == HPM_MODE_CHAN_B;

	// shared pins gathered into the parallel bus picture
	assign par_pins.ce_n = channel_a_select_n;
	assign par_pins.oe_n = pin_oe_n_sck_a;
	assign par_pins.we_n = pin_we_n_mosi_a;
	assign par_pins.addr = {pin_a4_in, pin_a3_mosi_b, channel_b_serial_clock, channel_b_select_n, pin_a0_in};
	assign par_pins.data = bus_data_in;
	assign par_pins.parity = bus_parity_bit_in;

	// write completes on the rising write enable while chip enable was low
	assign par_write_end = mode_par && !in_reset && !par_prev.ce_n && !par_prev.we_n && par_s2.we_n;
	assign par_parity_ok = par_prev.parity == hpm_parity(par_prev.addr, par_prev.data);
	assign par_reading = mode_par && !par_s2.ce_n && !par_s2.oe_n;

	// serial selects only act in their own mode
	assign sel_a_n = channel_a_select_n || !mode_a;
	assign sel_b_n = channel_b_select_n || !mode_b;

	assign tog_pulse = tog_s2 ^ tog_s3;
	assign spi_write = !in_reset && ((mode_a && tog_pulse[3]) || (mode_b && tog_pulse[1]));
	assign spi_frame = mode_a ? frame_a : frame_b;

	assign any_write = (par_write_end && par_parity_ok) || spi_write;
	assign next_wr = par_write_end ? hpm_wr_t'{addr: par_prev.addr, data: par_prev.data} : spi_frame;
	assign soft_reset = any_write && next_wr.addr == MASTER_RESET_ADDR && next_wr.data == MASTER_RESET_MAGIC;

	assign in_reset = !rst_pin_s2 || rst_cnt != '0;
	assign settings_reset = in_reset;

	always_comb
	begin
		next_ack = write_ack_n;
		if (par_write_end && !par_parity_ok)
			next_ack = ACK_ERROR;
		else if (any_write)
			next_ack = ACK_GOOD;
	end

	always_comb
	begin
		next_rd_addr = reg_rd_addr;
		if (mode_par)
			next_rd_addr = par_s2.addr;
		else if (mode_a && tog_pulse[2])
			next_rd_addr = rd_addr_a;
		else if (mode_b && tog_pulse[0])
			next_rd_addr = rd_addr_b;
	end

	// serial channels
	hpm_spi_chan u_chan_a (
		.sck(pin_oe_n_sck_a),
		.sel_n(sel_a_n),
		.mosi(pin_we_n_mosi_a),
		.miso(miso_a),
		.nrst(nrst),
		.rd_word(rd_hold),
		.frame(frame_a),
		.rd_addr(rd_addr_a),
		.wr_toggle(tog[3]),
		.rd_toggle(tog[2])
	);

	hpm_spi_chan u_chan_b (
		.sck(channel_b_serial_clock),
		.sel_n(sel_b_n),
		.mosi(pin_a3_mosi_b),
		.miso(miso_b),
		.nrst(nrst),
		.rd_word(rd_hold),
		.frame(frame_b),
		.rd_addr(rd_addr_b),
		.wr_toggle(tog[1]),
		.rd_toggle(tog[0])
	);

	// pin drivers
	assign pin_a0_out = miso_a;
	assign pin_a0_oe = mode_a;
	assign pin_a4_out = miso_b;
	assign pin_a4_oe = mode_b;
	assign bus_data_out = rd_hold;
	assign bus_data_oe = par_reading;
	assign bus_parity_bit_out = rd_parity;
	assign bus_parity_bit_oe = par_reading;

	// two-flop synchronisers for every pin and for the channel toggles
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			par_s1 <= '1;
			par_s2 <= '1;
			par_prev <= '1;
			strap_s1 <= 2'b11;
			strap_s2 <= 2'b11;
			rst_pin_s1 <= 1'b0;
			rst_pin_s2 <= 1'b0;
			comp_s1 <= 8'h00;
			comp_s2 <= 8'h00;
			lvf_s1 <= 3'h0;
			lvf_s2 <= 3'h0;
			tog_s1 <= 4'h0;
			tog_s2 <= 4'h0;
			tog_s3 <= 4'h0;
		end
		else
		begin
			par_s1 <= par_pins;
			par_s2 <= par_s1;
			par_prev <= par_s2;
			strap_s1 <= {strap_chan_a, strap_chan_b};
			strap_s2 <= strap_s1;
			rst_pin_s1 <= pin_reset_n;
			rst_pin_s2 <= rst_pin_s1;
			comp_s1 <= bilevel_in;
			comp_s2 <= comp_s1;
			lvf_s1 <= low_voltage_flag;
			lvf_s2 <= lvf_s1;
			tog_s1 <= tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end

	// reset stretch, strap capture and power-on ready
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_cnt <= CNT_W'(RESET_STRETCH);
			por_cnt <= '0;
			power_on_ready <= 1'b0;
			host_mode <= HPM_MODE_NONE;
		end
		else
		begin
			if (!rst_pin_s2 || soft_reset)
				rst_cnt <= CNT_W'(RESET_STRETCH);
			else if (rst_cnt != '0)
				rst_cnt <= rst_cnt - CNT_W'(1);
			if (in_reset)
				host_mode <= hpm_decode_mode(strap_s2[1], strap_s2[0]);
			if (por_cnt != CNT_W'(POR_READY))
				por_cnt <= por_cnt + CNT_W'(1);
			else
				power_on_ready <= 1'b1;
		end
	end

	// register file port and acknowledge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_wr_valid <= 1'b0;
			reg_wr <= '0;
			reg_rd_addr <= '0;
			rd_hold <= 8'h00;
			rd_parity <= 1'b0;
			write_ack_n <= ACK_IDLE;
		end
		else
		begin
			reg_wr_valid <= any_write;
			if (any_write)
				reg_wr <= next_wr;
			reg_rd_addr <= next_rd_addr;
			rd_hold <= reg_rd_data;
			rd_parity <= hpm_parity(reg_rd_addr, reg_rd_data);
			write_ack_n <= rst_pin_s2 ? next_ack : ACK_IDLE;
		end
	end

	// bilevel outputs, supply flags replace comparators 5 to 7 and power-on ready replaces 8 in reset
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bilevel_out_1_to_4 <= 4'h0;
			bilevel_out_5 <= 1'b0;
			bilevel_out_6 <= 1'b0;
			bilevel_out_7 <= 1'b0;
			bilevel_out_8 <= 1'b0;
		end
		else
		begin
			bilevel_out_1_to_4 <= comp_s2[3:0];
			bilevel_out_5 <= in_reset ? lvf_s2[LVF_VCC_BIT] : comp_s2[4];
			bilevel_out_6 <= in_reset ? lvf_s2[LVF_VEE_BIT] : comp_s2[5];
			bilevel_out_7 <= in_reset ? lvf_s2[LVF_5V_BIT] : comp_s2[6];
			bilevel_out_8 <= in_reset ? power_on_ready : comp_s2[7];
		end
	end

endmodule

/* File: src/hpm_spi_chan.sv */
// one serial channel slave, clocked by the host serial clock
`timescale 1ns/1ps
module hpm_spi_chan
	import hpm_pkg::*;
(
	// serial link
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso,
	// system side
	input wire logic nrst,
	input wire logic [DATA_W-1:0] rd_word,
	output hpm_wr_t frame,
	output logic [ADDR_W-1:0] rd_addr,
	output logic wr_toggle,
	output logic rd_toggle
);

	logic [3:0] bit_cnt;
	logic [14:0] in_sh;
	logic [DATA_W-1:0] out_sh;
	logic [15:0] word_now;

	assign word_now = {in_sh, mosi};
	assign miso = out_sh[DATA_W-1];

	// frame position, cleared whenever select is released
	always_ff @(posedge sck or posedge sel_n)
	begin
		if (sel_n)
		begin
			bit_cnt <= 4'h0;
			in_sh <= 15'h0000;
		end
		else
		begin
			bit_cnt <= bit_cnt + 4'h1;
			in_sh <= word_now[14:0];
		end
	end

	// events survive deselect so the system side never sees a false toggle
	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
		begin
			frame <= '0;
			rd_addr <= '0;
			wr_toggle <= 1'b0;
			rd_toggle <= 1'b0;
		end
		else if (!sel_n && bit_cnt == SPI_CMD_LAST && !word_now[7])
		begin
			rd_addr <= word_now[ADDR_W-1:0];
			rd_toggle <= ~rd_toggle;
		end
		else if (!sel_n && bit_cnt == SPI_FRAME_LAST && word_now[SPI_WRITE_BIT])
		begin
			frame <= {word_now[12:8], word_now[7:0]};
			wr_toggle <= ~wr_toggle;
		end
	end

	// reply byte is shifted out on falling edges, msb first
	always_ff @(negedge sck or posedge sel_n)
	begin
		if (sel_n)
			out_sh <= 8'h00;
		else if (bit_cnt == SPI_DATA_FIRST)
			out_sh <= rd_word;
		else
			out_sh <= {out_sh[DATA_W-2:0], 1'b0};
	end

endmodule
